// >>> hdl/osw_pkg.sv
/*
  Constants, types and register layout for the internal oscillator
  select and clock switch block.
  Assumes a 20 MHz register clock and a 32-bit Avalon-MM slave port.
*/
package osw_pkg;
  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] OFF_OSC_CONTROL   = 4'h0; // Control word
  localparam logic [3:0] OFF_OSC_STATUS    = 4'h4; // Status word
  localparam logic [3:0] OFF_TIMER_ONE_CTL = 4'h8; // Secondary osc enable
  // Control fields
  localparam int          SCS_LSB  = 0;
  localparam int          IFS_LSB  = 3;
  localparam int          SPLL_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0038; // Freq code 0111
  // Status fields
  localparam int ST_STARTUP_TIMER_STATUS = 0;
  localparam int ST_LF   = 1;
  localparam int ST_MF   = 2;
  localparam int ST_HF   = 3;
  localparam int ST_SECR = 4;
  localparam int ST_PLL  = 5;
  localparam int ST_BUSY = 6;
  // Timer-one control field
  localparam int SOSC_EN_BIT = 3;
  // ------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------
  localparam logic [3:0] IFS_RESET   = 4'h7; // 500 kHz after reset
  localparam logic [3:0] IFS_PLL_8M  = 4'he; // 8 MHz code used with PLL
  localparam logic [1:0] SCS_DEFAULT = 2'h0;
  localparam logic [1:0] SCS_SEC     = 2'h1;
  localparam logic [2:0] MODE_LPX    = 3'h0; // Low power crystal
  localparam logic [2:0] MODE_XT     = 3'h1; // Medium crystal
  localparam logic [2:0] MODE_HS     = 3'h2; // High speed crystal
  localparam logic [2:0] MODE_INTERNAL_OSC_BLOCK = 3'h4; // Internal block default
  // Start-up timing
  localparam int OST_CYCLES = 1024; // Crystal and secondary osc cycles
  localparam int LF_SYNC    = 2;    // Low osc sync cycles
  // Source of each frequency code, two bits per code, code 0 in low bits
  // 0 low osc, 1 mid osc, 2 high osc
  localparam logic [31:0] FREQ_SRC_TABLE = 32'haaaa_5550;
  // Clock sources, also the index into the source clock vector
  typedef enum logic [2:0] {
    SRC_LF = 3'h0, SRC_MF = 3'h1, SRC_HF = 3'h2,
    SRC_SEC = 3'h3, SRC_EXT = 3'h4, SRC_PLL = 3'h5
  } osw_src_e;
  localparam int NSRC = 6;
  // Switch sequencer, Gray from SW_IDLE through SW_DONE; SW_DONE back to SW_IDLE flips two bits
  typedef enum logic [2:0] {
    SW_IDLE = 3'h0, SW_START = 3'h1, SW_FALL = 3'h3,
    SW_RISE = 3'h2, SW_DONE = 3'h6
  } osw_state_e;
endpackage

// >>> hdl/osw_clock_switch.sv
/*
  Internal oscillator select and glitch-free system clock switch.
  Assumes oscillator clock levels arrive slow enough to be sampled by
  mclk, and that the analog oscillators report ready on their own pins.
*/
// Function
// RULE_01 - Internal oscillators feed one frequency mux
// RULE_02 - Twelve binary frequencies plus low oscillator
// RULE_03 - Reset loads frequency code 0111
// RULE_04 - Duplicate codes reach frequencies from sources
// RULE_05 - PLL output only under exact settings
// RULE_06 - PLL enabled by software or configuration
// RULE_07 - No PLL while source select is 1x
// RULE_08 - Start stopped oscillator, wait its delay
// RULE_09 - Fall of old, hold low, rise new
// RULE_10 - Status reports oscillators, updated at end
// RULE_11 - Same source switch skips start-up delay
// RULE_12 - Low osc two-cycle sync, off when left
// RULE_13 - Source select: default, secondary, internal
// RULE_14 - Reset clears source select
// RULE_15 - Automatic switches keep source select unchanged
// RULE_16 - Start-up status shows external source active; code shows crystal start-up timer expiry instead
// RULE_17 - Secondary oscillator runs only when enabled
// RULE_18 - Software selects secondary only after ready
// RULE_19 - Crystal and secondary wait 1024 cycles
// RULE_20 - High source derived from mid oscillator
// RULE_21 - Frequency code sources from parameter table
`timescale 1ns/1ns
`default_nettype none
module osw_clock_switch #(
  parameter logic [31:0] FREQ_SRC = osw_pkg::FREQ_SRC_TABLE,
  parameter int          OST_CNT  = osw_pkg::OST_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Configuration straps and neighbours
  input  wire logic [2:0]  cfg_osc_mode,
  input  wire logic        cfg_pll_enable,
  input  wire logic        cfg_two_speed,
  input  wire logic        watchdog_enable,
  input  wire logic        failsafe_enable,
  // Source clock levels, indexed by source code
  input  wire logic [5:0]  src_clk,
  // Ready pins of high, mid and low oscillators
  input  wire logic        hf_ready,
  input  wire logic        mf_ready,
  input  wire logic        lf_ready,
  // Oscillator controls and switched clock
  output logic             hf_osc_en,
  output logic             mf_osc_en,
  output logic             lf_osc_en,
  output logic             pll_en,
  output logic             sec_osc_run,
  output logic [3:0]       post_freq_sel,
  output logic [2:0]       active_src,
  output logic             sys_clk
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  clk_s1;   // First sync stage, read by clk_s2 only
    logic [5:0]  clk_s2;   // Synced source levels
    logic [5:0]  clk_prev; // Previous synced levels for edges
    logic [2:0]  rdy_s1;   // First sync stage of ready pins
    logic [2:0]  rdy_s2;   // Synced ready {hf,mf,lf}
    logic [1:0]  scs;      // Source select
    logic [3:0]  ifs;      // Frequency select
    logic        spll;     // Software PLL enable
    logic        sosc_en;  // Secondary oscillator enable
    logic [10:0] ost_cnt;  // External start-up count
    logic        startup_timer_status;     // Start-up timer expired
    logic [10:0] sec_cnt;  // Secondary start-up count
    logic        sec_rdy;  // Secondary ready
    logic [1:0]  lf_cnt;   // Low oscillator sync count
    osw_pkg::osw_state_e st;
    logic [2:0]  cur_src;  // Running source
    logic [2:0]  tgt_src;  // Source being switched to
    logic [3:0]  cur_frq;  // Running frequency code
    logic [3:0]  tgt_frq;  // Frequency code being switched to
    logic [2:0]  ostat;    // Reported {hf,mf,lf}
    logic        sclk;     // System clock level
    logic [3:0]  osc_en;   // {pll,hf,mf,lf}
    logic        wreq;     // Waitrequest
    logic [31:0] rdata;    // Read data
  } osw_state_s;

  osw_state_s s_reg;
  osw_state_s s_next;

  // Counter widths and limits, sized to the counters
  localparam logic [10:0] OST_LAST = 11'(OST_CNT - 1);
  localparam logic [1:0]  LF_LAST  = 2'(osw_pkg::LF_SYNC);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Oscillator behind a frequency code
  function automatic logic [2:0] code_src(input logic [3:0] code);
    code_src = {1'b0, FREQ_SRC[{code, 1'b0} +: 2]}; // [RULE_21] [RULE_04]
  endfunction

  // Crystal modes use the start-up timer
  function automatic logic is_crystal(input logic [2:0] m);
    is_crystal = (m == osw_pkg::MODE_LPX) || (m == osw_pkg::MODE_XT) ||
                 (m == osw_pkg::MODE_HS);
  endfunction

  // Rising edge of a synced source level
  function automatic logic rise(input logic [5:0] now, input logic [5:0] pre,
                                input logic [2:0] i);
    rise = now[i] & ~pre[i];
  endfunction

  // Combinational terms read by the next-state process
  logic       pll_on;   // PLL request
  logic [2:0] want_src; // Source the settings ask for
  logic       want_rdy; // Wanted source has started
  logic [1:0] a_idx;    // Word index of the bus access
  logic       acc;      // Access taken this cycle

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Input synchronisers
    s_next.clk_s1   = src_clk;
    s_next.clk_s2   = s_reg.clk_s1;
    s_next.clk_prev = s_reg.clk_s2;
    s_next.rdy_s1   = {hf_ready, mf_ready, lf_ready};
    s_next.rdy_s2   = s_reg.rdy_s1;

    // PLL only from internal default, source select 00, 8 MHz code
    pll_on = (s_reg.spll | cfg_pll_enable) &&                        // [RULE_06]
             cfg_osc_mode == osw_pkg::MODE_INTERNAL_OSC_BLOCK &&
             s_reg.scs == osw_pkg::SCS_DEFAULT &&                     // [RULE_07]
             s_reg.ifs == osw_pkg::IFS_PLL_8M;                        // [RULE_05]

    // Source choice; two-speed start keeps source select untouched
    if (s_reg.scs[1]) begin
      want_src = code_src(s_reg.ifs);                                 // [RULE_13]
    end else if (s_reg.scs == osw_pkg::SCS_SEC) begin
      want_src = osw_pkg::SRC_SEC;                                    // [RULE_13]
    end else if (cfg_osc_mode == osw_pkg::MODE_INTERNAL_OSC_BLOCK) begin
      want_src = pll_on ? osw_pkg::SRC_PLL : code_src(s_reg.ifs);
    end else if (is_crystal(cfg_osc_mode) && cfg_two_speed && !s_reg.startup_timer_status) begin
      want_src = code_src(s_reg.ifs);                                 // [RULE_15]
    end else begin
      want_src = osw_pkg::SRC_EXT;
    end

    // Start-up done for the target source
    unique case (s_reg.tgt_src)
      osw_pkg::SRC_LF:  want_rdy = s_reg.rdy_s2[0] && s_reg.lf_cnt == LF_LAST;
      osw_pkg::SRC_MF:  want_rdy = s_reg.rdy_s2[1];
      osw_pkg::SRC_HF,
      osw_pkg::SRC_PLL: want_rdy = s_reg.rdy_s2[2] && s_reg.rdy_s2[1]; // [RULE_20]
      osw_pkg::SRC_SEC: want_rdy = s_reg.sec_rdy;                      // [RULE_19]
      default:          want_rdy = s_reg.startup_timer_status || !is_crystal(cfg_osc_mode);
    endcase

    // Crystal start-up timer counts external clock edges
    if (!is_crystal(cfg_osc_mode)) begin
      s_next.startup_timer_status = 1'b0;
    end else if (!s_reg.startup_timer_status && rise(s_reg.clk_s2, s_reg.clk_prev, osw_pkg::SRC_EXT)) begin
      s_next.ost_cnt = s_reg.ost_cnt + 11'h001;                       // [RULE_19]
      s_next.startup_timer_status    = (s_reg.ost_cnt == OST_LAST);                   // [RULE_16]
    end

    // Secondary oscillator start-up count, cleared when disabled
    if (!s_reg.sosc_en) begin
      s_next.sec_cnt = 11'h000;                                       // [RULE_17]
      s_next.sec_rdy = 1'b0;
    end else if (!s_reg.sec_rdy && rise(s_reg.clk_s2, s_reg.clk_prev, osw_pkg::SRC_SEC)) begin
      s_next.sec_cnt = s_reg.sec_cnt + 11'h001;                       // [RULE_19]
      s_next.sec_rdy = (s_reg.sec_cnt == OST_LAST);
    end

    // Switch sequencer
    unique case (s_reg.st)
      osw_pkg::SW_IDLE: begin
        s_next.sclk = s_reg.clk_s2[s_reg.cur_src];
        if (want_src != s_reg.cur_src || s_reg.ifs != s_reg.cur_frq) begin
          s_next.tgt_src = want_src;
          s_next.tgt_frq = s_reg.ifs;
          s_next.lf_cnt  = 2'h0;
          // Same oscillator: no start-up delay
          s_next.st = (want_src == s_reg.cur_src) ? osw_pkg::SW_FALL  // [RULE_11]
                                                  : osw_pkg::SW_START;
        end
      end
      osw_pkg::SW_START: begin
        s_next.sclk = s_reg.clk_s2[s_reg.cur_src];
        // Low oscillator needs sync edges after its ready
        if (s_reg.rdy_s2[0] && s_reg.lf_cnt != LF_LAST &&
            rise(s_reg.clk_s2, s_reg.clk_prev, osw_pkg::SRC_LF)) begin
          s_next.lf_cnt = s_reg.lf_cnt + 2'h1;                        // [RULE_12]
        end
        if (want_rdy) begin
          s_next.st = osw_pkg::SW_FALL;                               // [RULE_08]
        end
      end
      osw_pkg::SW_FALL: begin
        // Follow old clock until it falls, then hold low
        s_next.sclk = s_reg.clk_s2[s_reg.cur_src];
        if (s_reg.clk_prev[s_reg.cur_src] && !s_reg.clk_s2[s_reg.cur_src]) begin
          s_next.sclk = 1'b0;                                         // [RULE_09]
          s_next.st   = osw_pkg::SW_RISE;
        end
      end
      osw_pkg::SW_RISE: begin
        s_next.sclk = 1'b0;
        if (rise(s_reg.clk_s2, s_reg.clk_prev, s_reg.tgt_src)) begin
          s_next.sclk    = 1'b1;                                      // [RULE_09]
          s_next.cur_src = s_reg.tgt_src;
          s_next.cur_frq = s_reg.tgt_frq;                             // [RULE_01] [RULE_02]
          s_next.st      = osw_pkg::SW_DONE;
        end
      end
      osw_pkg::SW_DONE: begin
        s_next.sclk  = s_reg.clk_s2[s_reg.cur_src];
        s_next.ostat = s_reg.rdy_s2 & s_reg.osc_en[2:0];              // [RULE_10]
        s_next.st    = osw_pkg::SW_IDLE;
      end
      default: begin
        s_next.st = osw_pkg::SW_IDLE;
      end
    endcase

    // Oscillator enables: running source, target while switching
    s_next.osc_en = 4'h0;
    for (int k = 0; k < 2; k++) begin
      logic [2:0] u;
      u = (k == 0) ? s_reg.cur_src : s_reg.tgt_src;
      if (k == 0 || s_reg.st != osw_pkg::SW_IDLE) begin
        if (u == osw_pkg::SRC_PLL) begin
          s_next.osc_en[3] = 1'b1;                                    // [RULE_05]
        end
        if (u == osw_pkg::SRC_HF || u == osw_pkg::SRC_PLL) begin
          s_next.osc_en[2:1] = 2'h3;                                  // [RULE_20]
        end
        if (u == osw_pkg::SRC_MF) begin
          s_next.osc_en[1] = 1'b1;
        end
        if (u == osw_pkg::SRC_LF) begin
          s_next.osc_en[0] = 1'b1;
        end
      end
    end
    // Low oscillator stays on for watchdog or fail-safe monitor
    if (watchdog_enable || failsafe_enable) begin
      s_next.osc_en[0] = 1'b1;                                        // [RULE_12]
    end

    // Avalon slave: one wait cycle, answer at the next edge
    a_idx = address[3:2];
    acc   = (read || write) && !s_reg.wreq;
    s_next.wreq = !((read || write) && s_reg.wreq);
    if (acc && write) begin
      unique case ({a_idx, 2'h0})
        osw_pkg::OFF_OSC_CONTROL: begin
          s_next.scs  = writedata[osw_pkg::SCS_LSB +: 2];             // [RULE_13]
          s_next.ifs  = writedata[osw_pkg::IFS_LSB +: 4];
          // Software bit unavailable when the strap enables the PLL
          s_next.spll = writedata[osw_pkg::SPLL_BIT] && !cfg_pll_enable; // [RULE_06]
        end
        osw_pkg::OFF_TIMER_ONE_CTL: begin
          s_next.sosc_en = writedata[osw_pkg::SOSC_EN_BIT];           // [RULE_17]
        end
        default: begin
        end
      endcase
    end
    s_next.rdata = 32'h0000_0000;
    if ((read || write) && s_reg.wreq && read) begin
      unique case ({a_idx, 2'h0})
        osw_pkg::OFF_OSC_CONTROL: begin
          s_next.rdata[osw_pkg::SCS_LSB +: 2] = s_reg.scs;
          s_next.rdata[osw_pkg::IFS_LSB +: 4] = s_reg.ifs;
          s_next.rdata[osw_pkg::SPLL_BIT]     = s_reg.spll;
        end
        osw_pkg::OFF_OSC_STATUS: begin
          s_next.rdata[osw_pkg::ST_STARTUP_TIMER_STATUS] = s_reg.startup_timer_status;                // [RULE_16]
          s_next.rdata[osw_pkg::ST_LF]   = s_reg.ostat[0];            // [RULE_10]
          s_next.rdata[osw_pkg::ST_MF]   = s_reg.ostat[1];
          s_next.rdata[osw_pkg::ST_HF]   = s_reg.ostat[2];
          s_next.rdata[osw_pkg::ST_SECR] = s_reg.sec_rdy;             // [RULE_18]
          s_next.rdata[osw_pkg::ST_PLL]  = s_reg.osc_en[3];
          s_next.rdata[osw_pkg::ST_BUSY] = (s_reg.st != osw_pkg::SW_IDLE);
        end
        osw_pkg::OFF_TIMER_ONE_CTL: begin
          s_next.rdata[osw_pkg::SOSC_EN_BIT] = s_reg.sosc_en;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_reg          <= '0;
      s_reg.ifs      <= osw_pkg::IFS_RESET;                           // [RULE_03]
      s_reg.scs      <= osw_pkg::SCS_DEFAULT;                         // [RULE_14]
      s_reg.cur_src  <= osw_pkg::SRC_MF;
      s_reg.cur_frq  <= osw_pkg::IFS_RESET;
      s_reg.st       <= osw_pkg::SW_IDLE;
      s_reg.wreq     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign readdata      = s_reg.rdata;
  assign waitrequest   = s_reg.wreq;
  assign pll_en        = s_reg.osc_en[3];
  assign hf_osc_en     = s_reg.osc_en[2];
  assign mf_osc_en     = s_reg.osc_en[1];
  assign lf_osc_en     = s_reg.osc_en[0];
  assign sec_osc_run   = s_reg.sosc_en;                               // [RULE_17]
  assign post_freq_sel = s_reg.cur_frq;                               // [RULE_01]
  assign active_src    = s_reg.cur_src;
  assign sys_clk       = s_reg.sclk;
endmodule
`default_nettype wire

// >>> tb/osw_clock_switch_properties.sv
/*
  Port checks for the clock switch block.
  Assumes it is bound to osw_clock_switch and sees its bus, enable, frequency, source and clock ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module osw_clock_switch_props (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        watchdog_enable,
  input wire logic        failsafe_enable,
  input wire logic        hf_osc_en,
  input wire logic        mf_osc_en,
  input wire logic        lf_osc_en,
  input wire logic        pll_en,
  input wire logic [3:0]  post_freq_sel,
  input wire logic [2:0]  active_src,
  input wire logic        sys_clk
);
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_reset_vals: assert property (
    $rose(resetn) |-> post_freq_sel == 4'h7 && active_src == 3'h1 && !sys_clk)
    else $error("reset values wrong");
  a_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_ack_one: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer stands too long");
  a_read_idle: assert property (waitrequest |-> readdata == 32'h0)
    else $error("read data not zero while waiting");
  a_switch_edge: assert property (
    $changed(active_src) |-> sys_clk && !$past(sys_clk))
    else $error("switch without low hold and rise");
  a_lf_running: assert property (
    active_src == osw_pkg::SRC_LF |-> lf_osc_en)
    else $error("low osc not enabled while active");
  a_lf_left: assert property (
    $past(active_src) == osw_pkg::SRC_LF && active_src != osw_pkg::SRC_LF
    && !watchdog_enable && !failsafe_enable |-> ##[0:8] !lf_osc_en)
    else $error("low osc left running");
  a_lf_kept: assert property (
    watchdog_enable || failsafe_enable |=> lf_osc_en)
    else $error("low osc off while watchdog or monitor on");
  a_hf_derived: assert property (
    active_src == osw_pkg::SRC_HF |-> hf_osc_en && mf_osc_en)
    else $error("high osc active without its sources");
  a_pll_code: assert property (
    active_src == osw_pkg::SRC_PLL |-> pll_en && post_freq_sel == osw_pkg::IFS_PLL_8M)
    else $error("pll active under wrong settings");
endmodule
bind osw_clock_switch osw_clock_switch_props u_props (
  .mclk(mclk), .resetn(resetn), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest),
  .watchdog_enable(watchdog_enable), .failsafe_enable(failsafe_enable),
  .hf_osc_en(hf_osc_en), .mf_osc_en(mf_osc_en), .lf_osc_en(lf_osc_en),
  .pll_en(pll_en), .post_freq_sel(post_freq_sel), .active_src(active_src),
  .sys_clk(sys_clk)
);
`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench for the clock switch block.
  Assumes the bench stands in for oscillators and software.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, resetn, read, write, hold_mf, cfg_pll_enable;
  logic        hf_ready, mf_ready, lf_ready, sys_clk, sec_osc_run;
  logic        hf_osc_en, mf_osc_en, lf_osc_en, pll_en, waitrequest;
  logic        ext_run, two_speed, wdt_en;           // External run, straps
  logic [3:0]  address, post_freq_sel, code;
  logic [31:0] writedata, readdata, rdata;
  logic [2:0]  cfg_osc_mode, active_src;
  logic [5:0]  src_clk, run_en;
  int          fails, n_tests, cycles, cnt;
  int          hp [6] = '{7, 3, 2, 5, 4, 1};     // Half periods per source
  logic [3:0]  cor [5] = '{4'h0, 4'h5, 4'hf, 4'h1, 4'h8};

  osw_clock_switch #(.OST_CNT(8)) DUT (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cfg_osc_mode(cfg_osc_mode),
    .cfg_pll_enable(cfg_pll_enable), .cfg_two_speed(two_speed),
    .watchdog_enable(wdt_en), .failsafe_enable(1'b0), .src_clk(src_clk),
    .hf_ready(hf_ready), .mf_ready(mf_ready), .lf_ready(lf_ready),
    .hf_osc_en(hf_osc_en), .mf_osc_en(mf_osc_en), .lf_osc_en(lf_osc_en),
    .pll_en(pll_en), .sec_osc_run(sec_osc_run), .post_freq_sel(post_freq_sel),
    .active_src(active_src), .sys_clk(sys_clk)
  );

  // ----------------------------------------------------------------
  // Clock, oscillator stand-in and hang guard
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;
  assign run_en = {pll_en, ext_run, sec_osc_run, hf_osc_en, mf_osc_en, lf_osc_en};
  // Sources toggle only while enabled; ready one edge after enable, mid ready held off by hold_mf
  always @(posedge mclk) begin
    cnt <= cnt + 1;
    for (int i = 0; i < 6; i++) begin
      if (run_en[i] && cnt % hp[i] == 0) begin
        src_clk[i] <= ~src_clk[i];
      end
    end
    hf_ready <= hf_osc_en;
    mf_ready <= mf_osc_en & !hold_mf;
    lf_ready <= lf_osc_en;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rdata = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // Source that owns a frequency code
  function automatic logic [2:0] src_of(input logic [3:0] c);
    return (c < 4'h2) ? 3'h0 : (c < 4'h8) ? 3'h1 : 3'h2;
  endfunction

  // Write control, poll busy, check running source
  task automatic switch_to(input logic [31:0] ctl, input logic [2:0] src);
    bus(1'b1, 4'h0, ctl);
    repeat (3) @(posedge mclk);
    do begin
      bus(1'b0, 4'h4, 32'h0);
    end while (rdata[osw_pkg::ST_BUSY] !== 1'b0);
    @(negedge mclk);
    chk({29'h0, active_src}, {29'h0, src});
  endtask

  task automatic rst;
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(rdata, osw_pkg::CTRL_RESET);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 0; resetn = 0; read = 0; write = 0; hold_mf = 0;
    address = 0; writedata = 0; cfg_osc_mode = osw_pkg::MODE_INTERNAL_OSC_BLOCK;
    cfg_pll_enable = 0; src_clk = 0; hf_ready = 0; mf_ready = 0;
    lf_ready = 0; fails = 0; n_tests = 0; cycles = 0; cnt = 0;
    ext_run = 1; two_speed = 0; wdt_en = 0;
    void'($urandom(97186));
    rst();
    @(negedge mclk);
    chk({28'h0, post_freq_sel}, 32'h7);
    // Unmapped word ignores writes, reads zero
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rdata, 32'h0);
    // Frequency codes, corners then random
    for (int k = 0; k < 12; k++) begin
      code = (k < 5) ? cor[k] : 4'($urandom_range(15));
      switch_to({25'h0, code, 3'h2}, src_of(code));
      chk({28'h0, post_freq_sel}, {28'h0, code});
      bus(1'b0, 4'h4, 32'h0);
      chk({31'h0, rdata[osw_pkg::ST_LF + src_of(code)]}, 32'h1);
    end
    // Same source switch must not wait on mid ready
    // Watchdog keeps the low oscillator on after it is left
    wdt_en <= 1'b1;
    switch_to(32'h0000_0002, 3'h0);
    switch_to(32'h0000_002a, 3'h1);
    chk({31'h0, lf_osc_en}, 32'h1);
    wdt_en <= 1'b0;
    hold_mf <= 1'b1;
    switch_to(32'h0000_001a, 3'h1);
    chk({28'h0, post_freq_sel}, 32'h3);
    hold_mf <= 1'b0;
    // Secondary oscillator enable, ready, select, release
    bus(1'b1, 4'h8, 32'h0000_0008);
    @(negedge mclk);
    chk({31'h0, sec_osc_run}, 32'h1);
    rdata = 32'h0;
    while (rdata[osw_pkg::ST_SECR] !== 1'b1) bus(1'b0, 4'h4, 32'h0);
    switch_to(32'h0000_0039, 3'h3);
    switch_to(32'h0000_003a, 3'h1);
    bus(1'b1, 4'h8, 32'h0);
    @(negedge mclk);
    chk({31'h0, sec_osc_run}, 32'h0);
    // PLL under internal default, then refused with internal select
    switch_to(32'h0000_00f0, 3'h5);
    chk({31'h0, pll_en}, 32'h1);
    switch_to(32'h0000_00f2, 3'h2);
    @(posedge mclk);
    cfg_pll_enable <= 1'b1;
    bus(1'b1, 4'h0, 32'h0000_00f2);
    bus(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h0000_0072);
    // Crystal default: two-speed runs internal until the timer expires
    ext_run <= 1'b0;
    two_speed <= 1'b1;
    cfg_osc_mode <= osw_pkg::MODE_XT;
    switch_to(32'h0000_0038, 3'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h0000_0038);
    ext_run <= 1'b1;
    rdata = 32'h0;
    while (rdata[osw_pkg::ST_STARTUP_TIMER_STATUS] !== 1'b1) bus(1'b0, 4'h4, 32'h0);
    switch_to(32'h0000_0038, 3'h4);
    chk({31'h0, rdata[osw_pkg::ST_STARTUP_TIMER_STATUS]}, 32'h1);
    // Reset in mid-run restores control defaults
    rst();
    stop_test();
  end
endmodule
`default_nettype wire
